// File: fwg_flash_write_guard_bank_map.sv
// Purpose: write-protect gate and boot-mode address map in front of the flash array
// Assumes: cpu memory request is a one-cycle strobe, mode pins static in operation
// Notes: undefined control bits 2..0 read as zero
//
// overview of the block
// - one control register holds the unlock field and the bank bit
// - the register sits behind a small axi4-lite slave
// - a cpu strobe is mapped and gated in one registered stage
// - the flash request, rom select and blocked pulse follow one cycle later
//
// unlock field
// - reset leaves the field locked, so a stray write after reset is dropped
// - only the open code lets a cpu write reach the array
// - reserved codes are stored as written and behave like locked
// - storing them keeps readback honest for software that wrote them
// - the cost is that a bad code silently locks, it raises no error
//
// bank bit
// - reset selects the upper half
// - the bit matters only while the boot mode pins are set
// - in cpu mode it is stored and read back but steers nothing
//
// address map in boot mode
// - the rom window is checked first; it lies below both flash halves, so it shadows no flash
// - upper half: the cpu address is the flash address
// - lower half: the flash address is the cpu address less the offset
// - addresses below the selected half, other than the rom window, reach nothing at all
//
// command path
// - the low address bits go to the array for command matching
// - the upper bits stay in the full address for area selection
// - every write that maps to flash is treated as a command cycle and gated by the lock
// - reads pass whatever the lock says, so data polling keeps working
//
// parallel mode
// - the external writer drives the array and the guard is bypassed
// - the register stays reachable but has no effect in this mode
//
// limitations
// - mode pins are expected to stay put while the cpu is running
// - a mode change mid-access may give one mapped cycle under the old mode
// - the unused mode code decodes as cpu mode rather than as an error
`timescale 1ns/1ps
module fwg_flash_write_guard_bank_map (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // operating mode
    input wire fwg_pkg::fwg_mode_e mode,
    // axi4-lite write address and data
    input wire logic [fwg_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [fwg_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cpu side memory request
    input wire fwg_pkg::fwg_cpu_req_s cpuReq,
    // parallel programmer request
    input wire fwg_pkg::fwg_flash_req_s writerReq,
    // flash and boot rom side
    output fwg_pkg::fwg_flash_req_s flashReq,
    output logic romSel,
    output logic [10:0] romAddr,
    output logic cmdBlocked,
    output logic commandUnlocked,
    output logic upperFlashHalf
);
    import fwg_pkg::*;

    // register and bus state
    logic [3:0] unlock_q, unlock_d;
    logic bank_q, bank_d;
    logic awHeld_q, awHeld_d;
    logic wHeld_q, wHeld_d;
    logic [AXI_AW-1:0] awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic [3:0] wStrb_q, wStrb_d;
    logic bValid_q, bValid_d;
    logic [1:0] bResp_q, bResp_d;
    logic rValid_q, rValid_d;
    logic [1:0] rResp_q, rResp_d;
    logic [31:0] rData_q, rData_d;
    // write channel holders let address and data arrive in either order
    // the response is raised only once both have been taken
    // a second write cannot start before the response is accepted

    // map state
    fwg_flash_req_s flash_q, flash_d;
    logic romSel_q, romSel_d;
    logic [10:0] romAddr_q, romAddr_d;
    logic blocked_q, blocked_d;

    // handshake outputs, combinational from holding flags
    // readies drop while a channel is held, so no beat is ever lost
    // the read channel accepts again once its data has been taken
    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rresp = rResp_q;
    assign s_axi_rdata = rData_q;
    assign commandUnlocked = (unlock_q == UNLOCK_OPEN);
    assign upperFlashHalf = bank_q;
    assign flashReq = flash_q;
    assign romSel = romSel_q;
    assign romAddr = romAddr_q;
    assign cmdBlocked = blocked_q;

    // bus slave: address and data in either order, response after both
    // the register changes at the edge that raises the response
    // a write to any other address answers an error and changes nothing
    // a write without the low byte lane answers okay and changes nothing
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        unlock_d = unlock_q;
        bank_d = bank_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (awHeld_q && wHeld_q) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = RESP_SLVERR;
            if (awAddr_q[AXI_AW-1:2] == FLASH_CONTROL_ADDR[AXI_AW-1:2]) begin
                bResp_d = RESP_OKAY;
                // only the low byte carries the register; other codes are kept as written
                if (wStrb_q[0]) begin
                    unlock_d = wData_q[UNLOCK_MSB:UNLOCK_LSB];
                    bank_d = wData_q[BANK_BIT];
                end
            end
        end
        if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
    end

    // read channel: one word per request, unmapped answers slverr
    // read data is captured when the address is taken
    // later register writes do not disturb a read already answered
    // the upper bytes always read as zero
    always_comb begin
        rValid_d = rValid_q;
        rResp_d = rResp_q;
        rData_d = rData_q;
        if (s_axi_arvalid && s_axi_arready) begin
            rValid_d = 1'b1;
            rData_d = '0;
            rResp_d = RESP_SLVERR;
            if (s_axi_araddr[AXI_AW-1:2] == FLASH_CONTROL_ADDR[AXI_AW-1:2]) begin
                rResp_d = RESP_OKAY;
                rData_d[UNLOCK_MSB:UNLOCK_LSB] = unlock_q;
                rData_d[BANK_BIT] = bank_q;
                // low bits left zero, software must not rely on them
                rData_d[2:0] = 3'h0;
            end
        end else if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end
    end

    // address map and write-protect gate, one registered stage
    // the register value before the strobe edge decides the map
    // so a register write and a cpu access in one cycle use the old value
    // outputs are cleared by default, a miss simply produces nothing
    // a blocked write pulses the blocked flag for exactly one cycle
    always_comb begin
        flash_d = '0;
        romSel_d = 1'b0;
        romAddr_d = '0;
        blocked_d = 1'b0;
        unique case (mode)
            MODE_PARALLEL: begin
                // external writer drives the array directly
                flash_d = writerReq;
            end
            MODE_SERIAL_BOOT: begin
                if (cpuReq.valid && cpuReq.addr >= ROM_LO && cpuReq.addr <= ROM_HI) begin
                    romSel_d = 1'b1;
                    romAddr_d = cpuReq.addr[10:0];
                end else if (cpuReq.valid && bank_q && cpuReq.addr >= UPPER_FLASH_HALF_LO) begin
                    flash_d.valid = 1'b1;
                    flash_d.addr = cpuReq.addr;
                end else if (cpuReq.valid && !bank_q && cpuReq.addr >= LOWER_FLASH_HALF_LO) begin
                    flash_d.valid = 1'b1;
                    flash_d.addr = cpuReq.addr - LOWER_FLASH_HALF_OFFSET;
                end
            end
            default: begin
                // cpu mode ignores the bank bit entirely
                if (cpuReq.valid && cpuReq.addr >= FLASH_LO && cpuReq.addr <= FLASH_HI) begin
                    flash_d.valid = 1'b1;
                    flash_d.addr = cpuReq.addr;
                end
            end
        endcase
        if (mode != MODE_PARALLEL && flash_d.valid) begin
            flash_d.cmdAddr = cpuReq.addr[CMD_ADDR_BITS-1:0];
            flash_d.wdata = cpuReq.wdata;
            // writes are command cycles; drop them while locked
            if (cpuReq.write && unlock_q != UNLOCK_OPEN) begin
                flash_d.valid = 1'b0;
                blocked_d = 1'b1;
            end else begin
                flash_d.write = cpuReq.write;
            end
        end
    end

    // register stage, synchronous reset
    // every state bit lands here, the combinational blocks only compute
    // reset clears all valids so nothing reaches the array during reset
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            unlock_q <= UNLOCK_LOCKED;
            bank_q <= UPPER_HALF_RST;
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
            rValid_q <= 1'b0;
            rResp_q <= RESP_OKAY;
            rData_q <= '0;
            flash_q <= '0;
            romSel_q <= 1'b0;
            romAddr_q <= '0;
            blocked_q <= 1'b0;
        end else begin
            unlock_q <= unlock_d;
            bank_q <= bank_d;
            awHeld_q <= awHeld_d;
            wHeld_q <= wHeld_d;
            awAddr_q <= awAddr_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            rValid_q <= rValid_d;
            rResp_q <= rResp_d;
            rData_q <= rData_d;
            flash_q <= flash_d;
            romSel_q <= romSel_d;
            romAddr_q <= romAddr_d;
            blocked_q <= blocked_d;
        end
    end
endmodule // fwg_flash_write_guard_bank_map

// File: fwg_pkg.sv
// Purpose: shared constants and carriers for the flash write guard and bank map
// Assumes: 16-bit cpu address space, byte-wide flash
// Notes: register reached over axi4-lite; flash_control offset is a word index
package fwg_pkg;
    // register map (printed offset is an index, byte address is four times it)
    localparam logic [11:0] FLASH_CONTROL_IDX = 12'hfff;
    localparam logic [13:0] FLASH_CONTROL_ADDR = {FLASH_CONTROL_IDX, 2'b00};
    localparam int AXI_AW = 14;
    // field layout of flash_control
    localparam int UNLOCK_MSB = 7;
    localparam int UNLOCK_LSB = 4;
    localparam int BANK_BIT = 3;
    localparam logic [3:0] UNLOCK_LOCKED = 4'hc;
    localparam logic [3:0] UNLOCK_OPEN = 4'h3;
    localparam logic UPPER_HALF_RST = 1'b1;
    // address map
    localparam logic [15:0] FLASH_LO = 16'h1000;
    localparam logic [15:0] FLASH_HI = 16'hffff;
    localparam logic [15:0] ROM_LO = 16'h7800;
    localparam logic [15:0] ROM_HI = 16'h7fff;
    localparam logic [15:0] UPPER_FLASH_HALF_LO = 16'h8000;
    localparam logic [15:0] LOWER_FLASH_HALF_LO = 16'h9000;
    localparam logic [15:0] LOWER_FLASH_HALF_OFFSET = 16'h8000;
    localparam int CMD_ADDR_BITS = 12;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        MODE_CPU,
        MODE_SERIAL_BOOT,
        MODE_PARALLEL
    } fwg_mode_e;

    // cpu memory request as seen by the map
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [7:0] wdata;
    } fwg_cpu_req_s;

    // request presented to the flash array
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [11:0] cmdAddr;
        logic [7:0] wdata;
    } fwg_flash_req_s;
endpackage

// File: fwg_guard_asserts.sv
// Purpose: port checks for the flash guard and bank map
// Assumes: one clock domain, synchronous active-high reset
// Notes: map answers are checked one cycle after the cpu strobe
`timescale 1ns/1ps
module fwg_guard_asserts (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // watched ports
    input wire fwg_pkg::fwg_mode_e mode,
    input wire fwg_pkg::fwg_cpu_req_s cpuReq,
    input wire fwg_pkg::fwg_flash_req_s writerReq,
    input wire fwg_pkg::fwg_flash_req_s flashReq,
    input wire logic romSel,
    input wire logic [10:0] romAddr,
    input wire logic cmdBlocked,
    input wire logic commandUnlocked,
    input wire logic upperFlashHalf
);
    import fwg_pkg::*;
    // read strobes only, so the lock never masks the map checks
    wire rd = cpuReq.valid && !cpuReq.write;
    wire bt = rd && mode == MODE_SERIAL_BOOT;
    wire [15:0] ca = cpuReq.addr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_locked_write_drop: assert property (cpuReq.valid && cpuReq.write && !commandUnlocked
        && mode != MODE_PARALLEL |=> cmdBlocked && !flashReq.valid) else $error("locked write");
    a_reset_locked: assert property ($fell(rst) |-> !commandUnlocked && upperFlashHalf)
        else $error("reset state");
    a_cpu_true_addr: assert property (rd && mode == MODE_CPU && ca >= FLASH_LO
        |=> flashReq.valid && flashReq.addr == $past(ca)) else $error("cpu addr");
    a_cpu_low_hole: assert property (cpuReq.valid && mode == MODE_CPU && ca < FLASH_LO
        |=> !flashReq.valid && !romSel) else $error("hole mapped");
    a_rom_window: assert property (bt && ca >= ROM_LO && ca <= ROM_HI
        |=> romSel && !flashReq.valid && romAddr == $past(ca[10:0])) else $error("rom map");
    a_lower_half_map: assert property (bt && !upperFlashHalf && ca >= LOWER_FLASH_HALF_LO
        |=> flashReq.valid && flashReq.addr == $past(ca) - LOWER_FLASH_HALF_OFFSET) else $error("bank 0");
    a_upper_half_map: assert property (bt && upperFlashHalf && ca >= UPPER_FLASH_HALF_LO
        |=> flashReq.valid && flashReq.addr == $past(ca)) else $error("bank 1");
    a_cmd_low_bits: assert property (cpuReq.valid && mode != MODE_PARALLEL
        |=> !flashReq.valid || flashReq.cmdAddr == $past(ca[11:0])) else $error("cmd bits");
    a_writer_pass: assert property (mode == MODE_PARALLEL
        |=> flashReq == $past(writerReq)) else $error("writer path");
    c_blocked: cover property (cmdBlocked);
    c_rom: cover property (romSel);
    c_flash_write: cover property (flashReq.valid && flashReq.write);
endmodule // fwg_guard_asserts
bind fwg_flash_write_guard_bank_map fwg_guard_asserts u_chk (.clk_sys, .rst, .mode, .cpuReq,
    .writerReq, .flashReq, .romSel, .romAddr, .cmdBlocked, .commandUnlocked, .upperFlashHalf);

// File: fwg_cpu_model.sv
// Purpose: cpu core stand-in issuing byte reads and writes
// Assumes: one strobe per call, an idle cycle between calls
// Notes: address and data stay put between strobes, only valid drops
`timescale 1ns/1ps
module fwg_cpu_model (
    // clock
    input wire logic clk_sys,
    // memory request
    output fwg_pkg::fwg_cpu_req_s cpuReq
);
    import fwg_pkg::*;
    // idle until the first access
    initial cpuReq = '0;
    // one-cycle strobe, launched and dropped just after an edge
    task automatic access(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cpuReq <= '{1'b1, w, a, d};
        @(posedge clk_sys);
        cpuReq.valid <= 1'b0;
    endtask
endmodule // fwg_cpu_model

// File: testbench.sv
// Purpose: self-checking run of the flash guard and bank map
// Assumes: control register at byte 0x3ffc, map answers after one cycle
// Notes: undefined control bits 2..0 are masked from every compare
`timescale 1ns/1ps
module testbench;
    import fwg_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    fwg_mode_e mode = MODE_CPU;
    logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    fwg_cpu_req_s cpuReq;
    fwg_flash_req_s writerReq = '0, flashReq;
    logic romSel, cmdBlocked, commandUnlocked, upperFlashHalf;
    logic [10:0] romAddr;
    int numErrors = 0, cmpCount = 0;
    // 100 MHz system clock
    always #5 clk_sys = ~clk_sys;
    fwg_flash_write_guard_bank_map DUT (.*);
    fwg_cpu_model CPU (.clk_sys, .cpuReq);
    // verdict and end of run
    task automatic report_and_stop;
        $display("compares %0d mismatches %0d", cmpCount, numErrors);
        if (numErrors == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic give_up;
        numErrors++;
        report_and_stop;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            numErrors++;
            $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask
    // axi write: each channel released at its own handshake
    task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic awGo, wGo, bGo;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            // look at settled handshakes, act on them at the next rising edge
            @(negedge clk_sys);
            awGo = s_axi_awvalid && s_axi_awready;
            wGo = s_axi_wvalid && s_axi_wready;
            bGo = s_axi_bvalid;
            rr = s_axi_bresp;
            @(posedge clk_sys);
            if (awGo) s_axi_awvalid <= 1'b0;
            if (wGo) s_axi_wvalid <= 1'b0;
            if (bGo) break;
        end
        if (n == 40) give_up;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [13:0] a);
        int n;
        logic arGo, rGo;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(negedge clk_sys);
            arGo = s_axi_arvalid && s_axi_arready;
            rGo = s_axi_rvalid;
            rv = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge clk_sys);
            if (arGo) s_axi_arvalid <= 1'b0;
            if (rGo) break;
        end
        if (n == 40) give_up;
        s_axi_rready <= 1'b0;
    endtask
    // control register contents and the levels it drives
    task automatic reg_is(input logic [7:0] e);
        rd(FLASH_CONTROL_ADDR);
        check({rr, rv[31:3]}, {RESP_OKAY, 24'h0, e[7:3]});
        check({commandUnlocked, upperFlashHalf}, {e[7:4] == UNLOCK_OPEN, e[3]});
    endtask
    // one cpu strobe, answer kind {flash, rom, blocked} and target address
    task automatic cpu(input logic w, input logic [15:0] a, input logic [2:0] k,
        input logic [15:0] e);
        CPU.access(w, a, 8'h5a);
        #1;
        check({flashReq.valid, romSel, cmdBlocked, flashReq.valid ? flashReq.addr :
            romSel ? {5'h0, romAddr} : 16'h0}, {k, e});
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        reg_is(8'hc8);
        cpu(1'b1, 16'h2000, 3'b001, 16'h0);
        cpu(1'b0, 16'h1000, 3'b100, 16'h1000);
        cpu(1'b0, 16'hffff, 3'b100, 16'hffff);
        cpu(1'b0, 16'h0fff, 3'b000, 16'h0);
        $display("test reset and cpu map done");
        wr(FLASH_CONTROL_ADDR, 32'h30, 4'hf);
        reg_is(8'h30);
        cpu(1'b1, 16'hf000, 3'b100, 16'hf000);
        @(posedge clk_sys);
        mode <= MODE_SERIAL_BOOT;
        cpu(1'b0, 16'h7800, 3'b010, 16'h0);
        cpu(1'b0, 16'h7fff, 3'b010, 16'h07ff);
        cpu(1'b1, 16'hf000, 3'b100, 16'h7000);
        cpu(1'b0, 16'h9000, 3'b100, 16'h1000);
        cpu(1'b0, 16'h8fff, 3'b000, 16'h0);
        wr(FLASH_CONTROL_ADDR, 32'h38, 4'hf);
        cpu(1'b0, 16'h8000, 3'b100, 16'h8000);
        cpu(1'b0, 16'hf000, 3'b100, 16'hf000);
        $display("test boot map done");
        wr(FLASH_CONTROL_ADDR, 32'hc8, 4'hf);
        reg_is(8'hc8);
        cpu(1'b1, 16'hf000, 3'b001, 16'h0);
        wr(14'h0004, 32'h30, 4'hf);
        check(rr, RESP_SLVERR);
        rd(14'h0004);
        check({rr, rv}, {RESP_SLVERR, 32'h0});
        wr(FLASH_CONTROL_ADDR, 32'h30, 4'he);
        reg_is(8'hc8);
        $display("test relock and bus errors done");
        @(posedge clk_sys);
        mode <= MODE_PARALLEL;
        @(posedge clk_sys);
        writerReq <= '{1'b1, 1'b1, 16'h1234, 12'h234, 8'h77};
        @(posedge clk_sys);
        writerReq.valid <= 1'b0;
        #1;
        check({flashReq.valid, flashReq.addr, flashReq.wdata}, {1'b1, 16'h1234, 8'h77});
        $display("test parallel writer done");
        report_and_stop;
    end
endmodule // testbench
